//--- shared/fpes_pkg.sv
// Package with addresses, bit positions, reset values and state types.
// What this block does
// (RL1) Program one aligned 64-byte row at a time.
// (RL2) Program select arms latching from next flash write.
// (RL3) Controller sets page, then writes inside row.
// (RL4) Controller waits delays, sets high voltage, writes bytes.
// (RL5) Controller clears select, waits, clears high voltage.
// (RL6) Controller follows the timed mass erase order.
// (RL7) Sequences run from RAM or debug commands.
// (RL8) No wait or stop during a sequence.
// (RL9) Secured debug-path flash reads return zero.
// (RL10) Every reset copies option byte into shadow.
// (RL11) Security code zero engages, one disengages.
// (RL12) Mass erase then reset boots unsecured.
// (RL13) Shadow bits 7..1 read zero, writes ignored.
// (RL14) High voltage settable only after proper sequence.
// (RL15) Program and mass-erase select are interlocked.
// (RL16) Secured device ignores program select writes.
// (RL17) Page select gives address bits 13..6.
// (RL18) Page zero window reaches low RAM, index.
// (RL19) Direct address 14 is the indexed-data port.
// (RL20) Secured normal boot clears debug pin enable.
// (RL21) Controller delays are configurable bus-clock counts.
package fpes_pkg;

    // ==========================================================
    // Address map
    localparam logic [13:0] OPTION_SHADOW_ADDR = 14'h0210;
    localparam logic [13:0] FLASH_CONTROL_ADDR = 14'h0211;
    localparam logic [13:0] NV_OPTION_ADDR = 14'h3ffc;
    localparam logic [13:0] PAGE_SELECT_ADDR = 14'h001f;
    localparam logic [13:0] INDEX_DATA_ADDR = 14'h000e;
    localparam logic [13:0] INDEX_REG_ADDR = 14'h000f;
    localparam logic [13:0] FLASH_BASE_ADDR = 14'h2000;
    localparam logic [7:0] WINDOW_BLOCK = 8'h03;

    // ==========================================================
    // Field positions
    localparam int PGM_BIT = 0;
    localparam int MASS_BIT = 2;
    localparam int HIGH_VOLTAGE_ENABLE_BIT = 3;
    localparam int SECURITY_CODE_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic SECURITY_CODE_RESET = 1'b0;

    typedef enum logic {FPES_LOAD, FPES_RUN} fpes_phase_t;

    typedef struct packed {
        fpes_phase_t phase;
        logic program_select;
        logic mass;
        logic hv;
        logic [7:0] page;
        logic [7:0] x;
        logic security_code;
        logic mode_hi;
        logic dbg_pe;
        logic [7:0] row;
        logic row_ok;
        logic armed;
        logic rvalid;
        logic [7:0] rdata;
        logic prog_stb;
        logic [13:0] prog_addr;
        logic [7:0] prog_data;
    } fpes_state_t;

endpackage

//--- hdl/fpes_flash_ctrl.sv
// Flash program, mass erase, security and paging window control.
`timescale 1ns/1ps
module fpes_flash_ctrl (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic [13:0] CPU_ADDR,
    input wire logic [7:0] CPU_WDATA,
    input wire logic CPU_WR,
    input wire logic CPU_RD,
    input wire logic CPU_DEBUG,
    output logic CPU_BUSY,
    output logic RD_VALID,
    output logic [7:0] RD_DATA,
    output logic [13:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_WR,
    output logic MEM_RD,
    input wire logic [7:0] MEM_RDATA,
    input wire logic MODE_SEL_PIN,
    output logic DEBUG_PIN_EN,
    output logic DEBUG_LOCK,
    output logic HIGH_VOLTAGE_EN,
    output logic MASS_ERASE,
    output logic PROG_STB,
    output logic [13:0] PROG_ADDR,
    output logic [7:0] PROG_DATA
);

    // ==========================================================
    // Address resolution
    fpes_pkg::fpes_state_t q;
    fpes_pkg::fpes_state_t d;
    logic run;
    logic secured;
    logic [13:0] eff;
    logic in_flash;
    logic own_reg;
    logic blocked;

    function automatic logic [13:0] win_map(
        input logic [13:0] a,
        input logic [7:0] pg
    );
        if (a[13:6] == fpes_pkg::WINDOW_BLOCK) begin
            return {pg, a[5:0]}; // RL17
        end
        return a;
    endfunction

    assign run = (q.phase == fpes_pkg::FPES_RUN);
    // The shadow powers up as engaged so nothing leaks before load.
    assign secured = ~q.security_code; // RL11

    always_comb begin
        if (CPU_ADDR == fpes_pkg::INDEX_DATA_ADDR) begin
            eff = win_map({6'h00, q.x}, q.page); // RL19
        end else begin
            eff = win_map(CPU_ADDR, q.page); // RL18
        end
    end

    assign in_flash = (eff >= fpes_pkg::FLASH_BASE_ADDR);
    assign own_reg = (eff == fpes_pkg::OPTION_SHADOW_ADDR) ||
                     (eff == fpes_pkg::FLASH_CONTROL_ADDR) ||
                     (eff == fpes_pkg::PAGE_SELECT_ADDR) ||
                     (eff == fpes_pkg::INDEX_REG_ADDR);
    assign blocked = secured && (CPU_DEBUG || q.dbg_pe); // RL9

    // ==========================================================
    // Next state and memory port
    always_comb begin
        logic npgm;
        logic nmass;
        logic nhv;
        npgm = CPU_WDATA[fpes_pkg::PGM_BIT];
        nmass = CPU_WDATA[fpes_pkg::MASS_BIT];
        nhv = CPU_WDATA[fpes_pkg::HIGH_VOLTAGE_ENABLE_BIT];
        d = q;
        d.rvalid = 1'b0;
        d.prog_stb = 1'b0;
        MEM_ADDR = eff;
        MEM_WDATA = CPU_WDATA;
        MEM_WR = 1'b0;
        MEM_RD = 1'b0;
        if (!run) begin
            // Option byte fetch happens once after every reset.
            MEM_ADDR = fpes_pkg::NV_OPTION_ADDR;
            MEM_RD = 1'b1;
            d.security_code = MEM_RDATA[fpes_pkg::SECURITY_CODE_BIT]; // RL10 RL12
            d.mode_hi = MODE_SEL_PIN;
            d.dbg_pe = ~MODE_SEL_PIN; // RL20
            d.phase = fpes_pkg::FPES_RUN;
        end else if (CPU_WR) begin
            unique case (1'b1)
                eff == fpes_pkg::FLASH_CONTROL_ADDR: begin
                    if (secured) begin
                        d.program_select = q.program_select; // RL16
                    end else if (npgm) begin
                        d.program_select = q.program_select | (~q.mass & ~nmass); // RL15
                    end else begin
                        d.program_select = 1'b0;
                    end
                    if (nmass) begin
                        d.mass = q.mass | (~q.program_select & ~npgm); // RL15
                    end else begin
                        d.mass = 1'b0;
                    end
                    d.hv = nhv & (q.hv | (d.program_select & q.row_ok) |
                                  (d.mass & q.armed)); // RL14
                    if (!d.program_select && !d.mass && !d.hv) begin
                        d.row_ok = 1'b0;
                        d.armed = 1'b0;
                    end
                end
                eff == fpes_pkg::PAGE_SELECT_ADDR: begin
                    d.page = CPU_WDATA;
                end
                eff == fpes_pkg::INDEX_REG_ADDR: begin
                    d.x = CPU_WDATA;
                end
                eff == fpes_pkg::OPTION_SHADOW_ADDR: begin
                    d.security_code = q.security_code; // RL13
                end
                in_flash: begin
                    if (q.program_select && !q.hv && !q.row_ok) begin
                        d.row = eff[13:6]; // RL2
                        d.row_ok = 1'b1;
                    end
                    if (q.mass && !q.hv) begin
                        d.armed = 1'b1;
                    end
                    if (q.program_select && q.hv && q.row_ok &&
                        eff[13:6] == q.row) begin
                        d.prog_stb = 1'b1; // RL1
                        d.prog_addr = eff;
                        d.prog_data = CPU_WDATA;
                    end
                end
                default: begin
                    MEM_WR = 1'b1;
                end
            endcase
        end else if (CPU_RD) begin
            d.rvalid = 1'b1;
            unique case (1'b1)
                eff == fpes_pkg::FLASH_CONTROL_ADDR: begin
                    d.rdata = {4'h0, q.hv, q.mass, 1'b0, q.program_select};
                end
                eff == fpes_pkg::PAGE_SELECT_ADDR: begin
                    d.rdata = q.page;
                end
                eff == fpes_pkg::INDEX_REG_ADDR: begin
                    d.rdata = q.x;
                end
                eff == fpes_pkg::OPTION_SHADOW_ADDR: begin
                    d.rdata = {7'h00, q.security_code}; // RL13
                end
                in_flash && blocked: begin
                    d.rdata = 8'h00; // RL9
                end
                default: begin
                    MEM_RD = 1'b1;
                    d.rdata = MEM_RDATA;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q.phase <= fpes_pkg::FPES_LOAD;
            q.program_select <= 1'b0;
            q.mass <= 1'b0;
            q.hv <= 1'b0;
            q.page <= fpes_pkg::PAGE_RESET;
            q.x <= fpes_pkg::INDEX_RESET;
            q.security_code <= fpes_pkg::SECURITY_CODE_RESET;
            q.mode_hi <= 1'b1;
            q.dbg_pe <= 1'b0;
            q.row <= 8'h00;
            q.row_ok <= 1'b0;
            q.armed <= 1'b0;
            q.rvalid <= 1'b0;
            q.rdata <= 8'h00;
            q.prog_stb <= 1'b0;
            q.prog_addr <= 14'h0000;
            q.prog_data <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign CPU_BUSY = ~run;
    assign RD_VALID = q.rvalid;
    assign RD_DATA = q.rdata;
    assign DEBUG_PIN_EN = q.dbg_pe;
    assign DEBUG_LOCK = run && secured && q.mode_hi; // RL20
    assign HIGH_VOLTAGE_EN = q.hv; // RL14
    // Erase only runs once the arming write has been seen.
    assign MASS_ERASE = q.hv && q.mass && q.armed;
    assign PROG_STB = q.prog_stb;
    assign PROG_ADDR = q.prog_addr;
    assign PROG_DATA = q.prog_data;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    a_select_interlock: assert property ( // RL15
        !(q.program_select && q.mass))
        else $error("program and mass erase select both set");

    a_secure_pgm_lock: assert property ( // RL16
        run && secured && !q.program_select |=> !q.program_select)
        else $error("program select set while secured");

    a_hv_needs_seq: assert property ( // RL14
        $rose(q.hv) |-> (q.program_select && q.row_ok) || (q.mass && q.armed))
        else $error("high voltage set without proper sequence");

    a_blocked_read_zero: assert property ( // RL9
        run && CPU_RD && !CPU_WR && in_flash && blocked && !own_reg
        |=> RD_VALID && RD_DATA == 8'h00 && !PROG_STB)
        else $error("secured flash read was not blocked");

    a_prog_in_row: assert property ( // RL1
        PROG_STB |-> PROG_ADDR[13:6] == q.row && q.program_select && q.hv)
        else $error("byte programmed outside latched row");

    a_row_latch: assert property ( // RL2
        run && CPU_WR && in_flash && !own_reg && q.program_select && !q.hv &&
        !q.row_ok |=> q.row_ok && q.row == $past(eff[13:6]))
        else $error("row address not latched");

    a_shadow_read: assert property ( // RL13
        run && CPU_RD && !CPU_WR &&
        eff == fpes_pkg::OPTION_SHADOW_ADDR
        |=> RD_DATA[7:1] == 7'h00 && RD_DATA[0] == q.security_code)
        else $error("option shadow read wrong");

    // The sampled reset keeps the release edge itself, which still sees
    // the load phase, out of the checks that start in the load cycle.
    a_option_load: assert property ( // RL10
        RST_N && !run |-> MEM_RD && MEM_ADDR == fpes_pkg::NV_OPTION_ADDR
        ##1 run && q.security_code == $past(MEM_RDATA[0]))
        else $error("option byte not copied at reset");

    a_security_code_stable: assert property ( // RL11
        run |=> $stable(q.security_code))
        else $error("security changed without reset");

    a_page_map: assert property ( // RL17
        run && CPU_RD && !CPU_WR && CPU_ADDR[13:6] == 8'h03 &&
        !own_reg && !in_flash
        |-> MEM_RD && MEM_ADDR == {q.page, CPU_ADDR[5:0]})
        else $error("window access mapped wrong");

    a_index_port: assert property ( // RL19
        run && CPU_RD && !CPU_WR &&
        CPU_ADDR == fpes_pkg::INDEX_DATA_ADDR &&
        q.x[7:6] == 2'b00 && q.x != 8'h0f && q.x != 8'h1f
        |-> MEM_ADDR == {6'h00, q.x})
        else $error("indexed data port not used");

    a_debug_lock: assert property ( // RL20
        RST_N && !run && MODE_SEL_PIN && !MEM_RDATA[0]
        |=> !DEBUG_PIN_EN && DEBUG_LOCK)
        else $error("secured normal boot left debug open");

    a_unsecured_boot: assert property ( // RL12
        RST_N && !run && MEM_RDATA[0] |=> !DEBUG_LOCK && !secured)
        else $error("erased option byte left device secured");

    a_debug_pin_boot: assert property ( // RL20
        RST_N && !run |=> DEBUG_PIN_EN == !$past(MODE_SEL_PIN))
        else $error("debug pin enable not taken from mode pin");

    a_secured_no_prog: assert property ( // RL16
        secured |-> !PROG_STB)
        else $error("byte programmed while secured");

    a_shadow_write: assert property ( // RL13
        run && CPU_WR && eff == fpes_pkg::OPTION_SHADOW_ADDR
        |=> q.security_code == $past(q.security_code))
        else $error("option shadow changed by a write");

    a_index_write: assert property ( // RL18
        run && CPU_WR && CPU_ADDR == 14'h00cf && q.page == 8'h00
        |=> q.x == $past(CPU_WDATA))
        else $error("window offset 15 missed the index register");

    a_window_ram: assert property ( // RL18
        run && CPU_RD && !CPU_WR && CPU_ADDR == 14'h00ce &&
        q.page == 8'h00
        |-> MEM_RD && MEM_ADDR == fpes_pkg::INDEX_DATA_ADDR)
        else $error("window offset 14 missed physical RAM");

    c_row_program: cover property (PROG_STB ##[1:8] PROG_STB);
    c_mass_erase: cover property ($rose(MASS_ERASE));
    c_blocked_read: cover property (
        run && CPU_RD && in_flash && blocked);
    c_index_access: cover property (
        run && CPU_RD && CPU_ADDR == fpes_pkg::INDEX_DATA_ADDR);

endmodule

//--- sim/fpes_mem_model.sv
// Memory model standing behind the block: RAM, flash array and option byte.
`timescale 1ns/1ps
module fpes_mem_model #(
    parameter logic [7:0] NV_INIT = 8'hfe
) (
    input wire logic clk,
    input wire logic [13:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic prog_stb,
    input wire logic [13:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic mass_erase,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:16383];
    logic [7:0] last_q = 8'h00;

    // ==========================================================
    // Contents
    initial begin
        for (int i = 0; i < 16384; i++) begin
            mem[i] = (i >= 16'h2000) ? 8'hff : i[7:0];
        end
        mem[14'h3ffc] = NV_INIT;
    end

    // Programming can only clear bits; erase returns them to one.
    always @(posedge clk) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (prog_stb) begin
            mem[prog_addr] <= mem[prog_addr] & prog_data;
        end
        if (mass_erase) begin
            for (int i = 16'h2000; i < 16384; i++) begin
                mem[i] <= 8'hff;
            end
        end
        if (mem_rd) begin
            last_q <= mem[mem_addr];
        end
    end

    // Released data lines show the inverse of the last value read, never that value itself.
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule

//--- sim/flash_program_erase_security_test.sv
// Self-checking bench for the flash program, erase and security block.
`timescale 1ns/1ps
module flash_program_erase_security_test;
    logic REF_CLK = 1'b0;
    logic RST_N = 1'b0;
    logic [13:0] CPU_ADDR = 14'h0000;
    logic [7:0] CPU_WDATA = 8'h00;
    logic CPU_WR = 1'b0;
    logic CPU_RD = 1'b0;
    logic CPU_DEBUG = 1'b0;
    logic MODE_SEL_PIN = 1'b1;
    logic CPU_BUSY, RD_VALID, MEM_WR, MEM_RD, DEBUG_PIN_EN, DEBUG_LOCK;
    logic HIGH_VOLTAGE_EN, MASS_ERASE, PROG_STB;
    logic [7:0] RD_DATA, MEM_WDATA, MEM_RDATA, PROG_DATA;
    logic [13:0] MEM_ADDR, PROG_ADDR;
    int failures = 0;
    int comparisons = 0;
    localparam logic [13:0] CTL = fpes_pkg::FLASH_CONTROL_ADDR;
    localparam logic [13:0] PG = fpes_pkg::PAGE_SELECT_ADDR;
    localparam logic [13:0] OPT = fpes_pkg::OPTION_SHADOW_ADDR;

    always #12.5 REF_CLK = ~REF_CLK;

    fpes_flash_ctrl u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N),
        .CPU_ADDR(CPU_ADDR), .CPU_WDATA(CPU_WDATA), .CPU_WR(CPU_WR),
        .CPU_RD(CPU_RD), .CPU_DEBUG(CPU_DEBUG), .CPU_BUSY(CPU_BUSY),
        .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD),
        .MEM_RDATA(MEM_RDATA), .MODE_SEL_PIN(MODE_SEL_PIN),
        .DEBUG_PIN_EN(DEBUG_PIN_EN), .DEBUG_LOCK(DEBUG_LOCK),
        .HIGH_VOLTAGE_EN(HIGH_VOLTAGE_EN), .MASS_ERASE(MASS_ERASE),
        .PROG_STB(PROG_STB), .PROG_ADDR(PROG_ADDR), .PROG_DATA(PROG_DATA));

    fpes_mem_model u_mem (.clk(REF_CLK), .mem_addr(MEM_ADDR),
        .mem_wdata(MEM_WDATA), .mem_wr(MEM_WR), .mem_rd(MEM_RD),
        .prog_stb(PROG_STB), .prog_addr(PROG_ADDR), .prog_data(PROG_DATA),
        .mass_erase(MASS_ERASE), .mem_rdata(MEM_RDATA));

    // ==========================================================
    // Tasks
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Requests made during the load cycle would be dropped, so wait.
    task automatic do_reset(input logic mode);
        int n;
        @(posedge REF_CLK);
        RST_N <= 1'b0;
        MODE_SEL_PIN <= mode;
        repeat (2) @(posedge REF_CLK);
        RST_N <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(posedge REF_CLK);
            #1;
            if (CPU_BUSY === 1'b0) break;
        end
        if (n == 8) begin
            failures++;
            give_verdict();
        end
    endtask

    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        CPU_ADDR <= a;
        CPU_WDATA <= d;
        CPU_WR <= 1'b1;
        @(posedge REF_CLK);
        CPU_WR <= 1'b0;
        #1;
    endtask

    task automatic rdc(input logic [13:0] a, input logic [7:0] exp,
                       input logic dbg, input string what);
        @(posedge REF_CLK);
        CPU_ADDR <= a;
        CPU_DEBUG <= dbg;
        CPU_RD <= 1'b1;
        @(posedge REF_CLK);
        CPU_RD <= 1'b0;
        CPU_DEBUG <= 1'b0;
        #1;
        chk({15'h0, RD_VALID}, 16'h1, "read valid");
        chk({8'h0, RD_DATA}, {8'h0, exp}, what);
    endtask

    // ==========================================================
    // Sequence
    initial begin
        do_reset(1'b1);
        rdc(OPT, 8'h00, 1'b0, "shadow secured");
        chk({15'h0, DEBUG_PIN_EN}, 16'h0, "debug pin enable");
        chk({15'h0, DEBUG_LOCK}, 16'h1, "debug lock");
        wr(OPT, 8'hff);
        rdc(OPT, 8'h00, 1'b0, "shadow read only");
        wr(CTL, 8'h01);
        rdc(CTL, 8'h00, 1'b0, "select secured");
        rdc(14'h2000, 8'h00, 1'b1, "secured debug read");
        rdc(14'h2000, 8'hff, 1'b0, "secured user read");
        do_reset(1'b0);
        chk({15'h0, DEBUG_PIN_EN}, 16'h1, "debug pin boot");
        chk({15'h0, DEBUG_LOCK}, 16'h0, "debug boot lock");
        rdc(14'h2000, 8'h00, 1'b0, "pin enable read");
        wr(CTL, 8'h04);
        wr(PG, 8'h80);
        wr(14'h00c0, 8'haa);
        repeat (2) @(posedge REF_CLK);
        wr(CTL, 8'h0c);
        chk({15'h0, HIGH_VOLTAGE_EN}, 16'h1, "erase voltage");
        chk({15'h0, MASS_ERASE}, 16'h1, "mass erase");
        wr(CTL, 8'h08);
        chk({15'h0, MASS_ERASE}, 16'h0, "erase stop");
        wr(CTL, 8'h00);
        chk({15'h0, HIGH_VOLTAGE_EN}, 16'h0, "voltage off");
        do_reset(1'b0);
        rdc(OPT, 8'h01, 1'b0, "shadow unsecured");
        chk({15'h0, DEBUG_LOCK}, 16'h0, "debug open");
        wr(CTL, 8'h05);
        rdc(CTL, 8'h00, 1'b0, "interlock");
        wr(CTL, 8'h08);
        rdc(CTL, 8'h00, 1'b0, "voltage refused");
        wr(CTL, 8'h01);
        wr(PG, 8'h81);
        wr(14'h00c0, 8'h00);
        repeat (2) @(posedge REF_CLK);
        wr(CTL, 8'h09);
        rdc(CTL, 8'h09, 1'b0, "program voltage");
        wr(14'h00c5, 8'h5a);
        chk({15'h0, PROG_STB}, 16'h1, "program strobe");
        chk({2'h0, PROG_ADDR}, 16'h2045, "program address");
        chk({8'h0, PROG_DATA}, 16'h005a, "program data");
        wr(14'h2080, 8'h11);
        chk({15'h0, PROG_STB}, 16'h0, "outside row");
        wr(CTL, 8'h08);
        wr(CTL, 8'h00);
        rdc(14'h2045, 8'h5a, 1'b0, "programmed byte");
        wr(PG, 8'h00);
        wr(14'h0005, 8'h33);
        wr(14'h00cf, 8'h05);
        rdc(14'h000f, 8'h05, 1'b0, "index register");
        rdc(14'h000e, 8'h33, 1'b0, "indexed data");
        rdc(14'h00ce, 8'h0e, 1'b0, "window ram");
        wr(PG, 8'h04);
        rdc(14'h00c7, 8'h07, 1'b0, "paged block");
        give_verdict();
    end

    initial begin
        #200000;
        failures++;
        give_verdict();
    end
endmodule
